//--- src/jamc_axis.sv
// jog motion control for one axis with an ahb-lite register file
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps

module jamc_axis
  import jamc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        limit_upper,
  input  wire logic        limit_lower,
  output logic             pulse_out,
  output logic             dir_out,
  output logic             axis_busy_flag,
  output logic             speed_zero_flag
);

  //////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, always okay

  logic        a_val_q, a_val_d;
  logic        a_wr_q,  a_wr_d;
  logic [7:0]  a_adr_q, a_adr_d;
  logic        wr_en;

  always_comb begin
    a_val_d = 1'b0;
    a_wr_d  = a_wr_q;
    a_adr_d = a_adr_q;
    if (hsel && hready && htrans[1]) begin
      // outside the 256-byte window nothing decodes
      a_val_d = (haddr[31:8] == 24'h0) && (hsize == 3'h2);
      a_wr_d  = hwrite;
      a_adr_d = haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_val_q <= 1'b0;
      a_wr_q  <= 1'b0;
      a_adr_q <= 8'h00;
    end else begin
      a_val_q <= a_val_d;
      a_wr_q  <= a_wr_d;
      a_adr_q <= a_adr_d;
    end
  end

  assign wr_en     = a_val_q && a_wr_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [2:0]  ctrl_q,  ctrl_d;
  logic [31:0] jog_q,   jog_d;
  logic [31:0] new_q,   new_d;
  logic [31:0] lim_q,   lim_d;
  logic [31:0] bias_q,  bias_d;
  logic [31:0] acct_q,  acct_d;
  logic [31:0] dect_q,  dect_d;
  logic [31:0] swup_q,  swup_d;
  logic [31:0] swlo_q,  swlo_d;
  logic        spchg;
  logic        erst;

  always_comb begin
    ctrl_d = ctrl_q;
    jog_d  = jog_q;
    new_d  = new_q;
    lim_d  = lim_q;
    bias_d = bias_q;
    acct_d = acct_q;
    dect_d = dect_q;
    swup_d = swup_q;
    swlo_d = swlo_q;
    if (wr_en) begin
      case (a_adr_q)
        A_CTRL:   ctrl_d = hwdata[2:0];
        A_JOGSPD: jog_d  = hwdata;
        A_NEWSPD: new_d  = hwdata;
        A_LIMIT:  lim_d  = hwdata;
        A_BIAS:   bias_d = hwdata;
        A_ACCT:   acct_d = hwdata;
        A_DECT:   dect_d = hwdata;
        A_SWUP:   swup_d = hwdata;
        A_SWLO:   swlo_d = hwdata;
        default:  ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 3'h0;
      jog_q  <= RST_ZERO;
      new_q  <= RST_ZERO;
      lim_q  <= RST_LIMIT;
      bias_q <= RST_ZERO;
      acct_q <= RST_TIME;
      dect_q <= RST_TIME;
      swup_q <= RST_ZERO;
      swlo_q <= RST_ZERO;
    end else begin
      ctrl_q <= ctrl_d;
      jog_q  <= jog_d;
      new_q  <= new_d;
      lim_q  <= lim_d;
      bias_q <= bias_d;
      acct_q <= acct_d;
      dect_q <= dect_d;
      swup_q <= swup_d;
      swlo_q <= swlo_d;
    end
  end

  // command bits act once, on the write itself
  assign spchg = wr_en && (a_adr_q == A_CMD) && hwdata[CMD_SPCHG];
  assign erst  = wr_en && (a_adr_q == A_CMD) && hwdata[CMD_ERST];

  //////////////////////////////////////////////////////////////////////////
  // motion control

  jamc_state_t st_q, st_d;
  logic [31:0] spd_q,  spd_d;
  logic [31:0] tgt_q,  tgt_d;
  logic [31:0] stp_q,  stp_d;
  logic [31:0] feed_q, feed_d;
  logic [15:0] err_q,  err_d;
  logic [15:0] warn_q, warn_d;
  logic        jprv_q, jprv_d;
  logic        dir_q,  dir_d;
  logic [15:0] tick_q, tick_d;
  logic        tick;
  logic        pulse;
  logic        jog_on;
  logic        stop_on;
  logic        start_edge;
  logic        sw_en;
  logic        hw_hit;
  logic        sw_hit;
  logic [32:0] up_sum;

  assign jog_on     = ctrl_q[CTRL_JOG];
  assign stop_on    = ctrl_q[CTRL_STOP];
  // level command: only a rising edge starts, so a held start never
  // restarts after a stop or a deceleration
  assign start_edge = jog_on && !jprv_q;
  assign sw_en      = swup_q != swlo_q;
  assign tick       = tick_q == 16'(CTRL_CYCLE_CLKS - 1);
  assign hw_hit     = dir_q ? limit_lower : limit_upper;
  assign sw_hit     = sw_en && (dir_q ? $signed(feed_q) <= $signed(swlo_q)
                                      : $signed(feed_q) >= $signed(swup_q));

  always_comb begin
    st_d   = st_q;
    spd_d  = spd_q;
    tgt_d  = tgt_q;
    stp_d  = stp_q;
    feed_d = feed_q;
    err_d  = err_q;
    warn_d = warn_q;
    dir_d  = dir_q;
    jprv_d = jog_on;
    tick_d = tick ? 16'h0 : 16'(tick_q + 16'h1);
    up_sum = {1'b0, spd_q} + {1'b0, stp_q};
    if (erst) begin
      err_d  = 16'h0;
      warn_d = 16'h0;
    end
    if (pulse) feed_d = dir_q ? 32'(feed_q - 32'h1) : 32'(feed_q + 32'h1);
    // events below are assigned after the clear, so a set wins
    case (st_q)
      ST_IDLE: begin
        if (start_edge) begin
          dir_d = ctrl_q[CTRL_DIR];
          if (stop_on) begin
            err_d = ERR_STOP_ON;
          end else if (err_q != 16'h0) begin
            st_d = ST_IDLE;
          end else if (!ctrl_q[CTRL_DIR] && limit_upper) begin
            err_d = ERR_HW_UP;
          end else if (ctrl_q[CTRL_DIR] && limit_lower) begin
            err_d = ERR_HW_LO;
          end else if (sw_en && !ctrl_q[CTRL_DIR] &&
                       $signed(feed_q) >= $signed(swup_q)) begin
            err_d = ERR_SW_UP;
          end else if (sw_en && ctrl_q[CTRL_DIR] &&
                       $signed(feed_q) <= $signed(swlo_q)) begin
            err_d = ERR_SW_LO;
          end else if (jog_q == 32'h0 && bias_q == 32'h0) begin
            st_d  = ST_ZERO;
            spd_d = 32'h0;
          end else begin
            st_d  = ST_ACCEL;
            spd_d = 32'h0;
            tgt_d = jamc_clamp(jog_q, lim_q, bias_q);
            stp_d = jamc_step(jamc_clamp(jog_q, lim_q, bias_q), acct_q);
            if (jamc_oor(jog_q, lim_q, bias_q)) warn_d = WARN_RANGE;
          end
        end
      end
      ST_ACCEL, ST_CONST: begin
        if (!jog_on || stop_on || hw_hit || sw_hit) begin
          st_d  = ST_DECEL;
          stp_d = jamc_step(spd_q, dect_q);
          if (hw_hit) err_d = dir_q ? ERR_HW_LO : ERR_HW_UP;
          else if (sw_hit) err_d = dir_q ? ERR_SW_LO : ERR_SW_UP;
        end else if (spchg) begin
          st_d  = ST_ACCEL;
          tgt_d = jamc_clamp(new_q, lim_q, bias_q);
          stp_d = jamc_step(jamc_clamp(new_q, lim_q, bias_q), acct_q);
          if (jamc_oor(new_q, lim_q, bias_q)) warn_d = WARN_RANGE;
        end else if (tick && st_q == ST_ACCEL) begin
          // linear ramp toward the target, never past it
          if (spd_q < tgt_q) begin
            spd_d = (up_sum >= {1'b0, tgt_q}) ? tgt_q : up_sum[31:0];
          end else begin
            spd_d = (spd_q - tgt_q <= stp_q) ? tgt_q : 32'(spd_q - stp_q);
          end
          if (spd_d == tgt_q) st_d = ST_CONST;
        end
      end
      ST_DECEL: begin
        // speed change requests are dropped here
        if (tick) begin
          if (spd_q <= stp_q) begin
            spd_d = 32'h0;
            st_d  = ST_IDLE;
          end else begin
            spd_d = 32'(spd_q - stp_q);
          end
        end
      end
      ST_ZERO: begin
        // axis is stationary but still counts as busy
        if (!jog_on || stop_on) begin
          st_d = ST_IDLE;
        end else if (spchg && new_q != 32'h0) begin
          st_d  = ST_ACCEL;
          tgt_d = jamc_clamp(new_q, lim_q, bias_q);
          stp_d = jamc_step(jamc_clamp(new_q, lim_q, bias_q), acct_q);
          if (jamc_oor(new_q, lim_q, bias_q)) warn_d = WARN_RANGE;
        end
      end
      default: begin
        st_d  = ST_IDLE;
        spd_d = 32'h0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q   <= ST_IDLE;
      spd_q  <= 32'h0;
      tgt_q  <= 32'h0;
      stp_q  <= 32'h1;
      feed_q <= 32'h0;
      err_q  <= 16'h0;
      warn_q <= 16'h0;
      jprv_q <= 1'b0;
      dir_q  <= 1'b0;
      tick_q <= 16'h0;
    end else begin
      st_q   <= st_d;
      spd_q  <= spd_d;
      tgt_q  <= tgt_d;
      stp_q  <= stp_d;
      feed_q <= feed_d;
      err_q  <= err_d;
      warn_q <= warn_d;
      jprv_q <= jprv_d;
      dir_q  <= dir_d;
      tick_q <= tick_d;
    end
  end

  jamc_pulse_gen u_pulse (
    .hclk    (hclk),
    .hresetn (hresetn),
    .speed   (spd_q),
    .pulse   (pulse)
  );

  // busy covers every state but idle, so a start edge is ignored
  assign axis_busy_flag  = st_q != ST_IDLE;
  assign speed_zero_flag = st_q == ST_ZERO;
  assign pulse_out       = pulse;
  assign dir_out         = dir_q;

  //////////////////////////////////////////////////////////////////////////
  // read mux over register flops; unmapped words read zero

  always_comb begin
    hrdata = 32'h0;
    if (a_val_q && !a_wr_q) begin
      case (a_adr_q)
        A_CTRL:   hrdata = {29'h0, ctrl_q};
        A_JOGSPD: hrdata = jog_q;
        A_NEWSPD: hrdata = new_q;
        A_LIMIT:  hrdata = lim_q;
        A_BIAS:   hrdata = bias_q;
        A_ACCT:   hrdata = acct_q;
        A_DECT:   hrdata = dect_q;
        A_SWUP:   hrdata = swup_q;
        A_SWLO:   hrdata = swlo_q;
        A_STAT:   hrdata = {29'h0, dir_q, speed_zero_flag, axis_busy_flag};
        A_OPST:   hrdata = {24'h0, axis_busy_flag ? OPST_JOG : OPST_STOP};
        A_ERR:    hrdata = {16'h0, err_q};
        A_WARN:   hrdata = {16'h0, warn_q};
        A_SPEED:  hrdata = spd_q;
        A_FEED:   hrdata = feed_q;
        default:  hrdata = 32'h0;
      endcase
    end
  end

endmodule // jamc_axis

//--- src/jamc_pkg.sv
// constants, types and helpers shared by the jog axis block
package jamc_pkg;

  localparam int CLK_HZ          = 250_000_000;
  localparam int CLK_NS          = 4;
  localparam int CTRL_CYCLE_NS   = 1000;
  localparam int CTRL_CYCLE_CLKS = CTRL_CYCLE_NS / CLK_NS;
  localparam logic [32:0] CLK_HZ_W = 33'h00ee6b280;

  // register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CMD    = 8'h04;
  localparam logic [7:0] A_JOGSPD = 8'h08;
  localparam logic [7:0] A_NEWSPD = 8'h0c;
  localparam logic [7:0] A_LIMIT  = 8'h10;
  localparam logic [7:0] A_BIAS   = 8'h14;
  localparam logic [7:0] A_ACCT   = 8'h18;
  localparam logic [7:0] A_DECT   = 8'h1c;
  localparam logic [7:0] A_SWUP   = 8'h20;
  localparam logic [7:0] A_SWLO   = 8'h24;
  localparam logic [7:0] A_STAT   = 8'h28;
  localparam logic [7:0] A_OPST   = 8'h2c;
  localparam logic [7:0] A_ERR    = 8'h30;
  localparam logic [7:0] A_WARN   = 8'h34;
  localparam logic [7:0] A_SPEED  = 8'h38;
  localparam logic [7:0] A_FEED   = 8'h3c;

  // field positions
  localparam int CTRL_JOG  = 0;
  localparam int CTRL_DIR  = 1;
  localparam int CTRL_STOP = 2;
  localparam int CMD_SPCHG = 0;
  localparam int CMD_ERST  = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ZERO = 1;
  localparam int STAT_DIR  = 2;

  // error and warning codes (decimal 1100..1104, 1020)
  localparam logic [15:0] ERR_HW_UP    = 16'h044c;
  localparam logic [15:0] ERR_HW_LO    = 16'h044d;
  localparam logic [15:0] ERR_STOP_ON  = 16'h044e;
  localparam logic [15:0] ERR_SW_UP    = 16'h044f;
  localparam logic [15:0] ERR_SW_LO    = 16'h0450;
  localparam logic [15:0] WARN_RANGE   = 16'h03fc;
  localparam logic [7:0]  OPST_STOP    = 8'h00;
  localparam logic [7:0]  OPST_JOG     = 8'h02;

  // reset values
  localparam logic [31:0] RST_ZERO  = 32'h00000000;
  localparam logic [31:0] RST_LIMIT = 32'h000186a0;
  localparam logic [31:0] RST_TIME  = 32'h00000064;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ACCEL = 5'b00010,
    ST_CONST = 5'b00100,
    ST_DECEL = 5'b01000,
    ST_ZERO  = 5'b10000
  } jamc_state_t;

  function automatic logic [31:0] jamc_clamp(input logic [31:0] v,
                                             input logic [31:0] lim,
                                             input logic [31:0] bias);
    logic [31:0] r;
    r = v;
    if (v > lim) r = lim;
    else if (v < bias) r = bias;
    return r;
  endfunction

  function automatic logic jamc_oor(input logic [31:0] v,
                                    input logic [31:0] lim,
                                    input logic [31:0] bias);
    return (v > lim) || (v < bias);
  endfunction

  // per-cycle rate step of a linear ramp over t control cycles
  function automatic logic [31:0] jamc_step(input logic [31:0] span,
                                            input logic [31:0] t);
    logic [31:0] q;
    q = (t == 32'h0) ? span : span / t;
    if (q == 32'h0) q = 32'h1;
    return q;
  endfunction

endpackage

//--- src/jamc_pulse_gen.sv
// rate-to-pulse generator: emits speed pulses per second
`timescale 1ns/10ps
module jamc_pulse_gen
  import jamc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [31:0] speed,
  output logic             pulse
);

  logic [31:0] phase_q, phase_d;
  logic        pulse_q, pulse_d;
  logic [32:0] sum;

  // speeds at or above the clock rate saturate at one pulse per clock
  always_comb begin
    sum     = {1'b0, phase_q} + {1'b0, speed};
    phase_d = sum[31:0];
    pulse_d = 1'b0;
    if (sum >= CLK_HZ_W) begin
      phase_d = 32'(sum - CLK_HZ_W);
      pulse_d = 1'b1;
      if (phase_d >= 32'(CLK_HZ)) phase_d = 32'h0;
    end
    if (speed == 32'h0) phase_d = 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 32'h0;
      pulse_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;

endmodule // jamc_pulse_gen

//--- tb/jamc_axis_monitor.sv
// assertion checker on the jog axis top-level ports
`timescale 1ns/10ps
module jamc_axis_monitor
  import jamc_pkg::*;
#(parameter int STOP_CLKS = 2000)
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        limit_upper,
  input wire logic        limit_lower,
  input wire logic        pulse_out,
  input wire logic        dir_out,
  input wire logic        axis_busy_flag,
  input wire logic        speed_zero_flag
);
  logic        rd_q, rd_d;
  logic [3:0]  gap_q, gap_d;
  logic [15:0] hit_q, hit_d;
  logic        take;
  ////////////////////////////////////////////////////////////
  // hit_q counts cycles spent busy while pressing into a limit
  always_comb begin
    take  = hsel && hready && htrans[1];
    rd_d  = take && !hwrite;
    gap_d = (take && hwrite) ? 4'h0 : gap_q + {3'h0, gap_q != 4'hf};
    hit_d = 16'h0;
    if (axis_busy_flag && !speed_zero_flag &&
        (dir_out ? limit_lower : limit_upper))
      hit_d = hit_q + 16'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q  <= 1'b0;
      gap_q <= 4'hf;
      hit_q <= 16'h0;
    end else begin
      rd_q  <= rd_d;
      gap_q <= gap_d;
      hit_q <= hit_d;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_read_idle: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_busy_cause: assert property (
    $rose(axis_busy_flag) |-> gap_q <= 4'h4)
    else $error("busy rose without a recent write");
  a_pulse_short: assert property (pulse_out |=> !pulse_out)
    else $error("step pulse longer than one cycle");
  a_idle_quiet: assert property (
    (!axis_busy_flag)[*4] |-> !pulse_out)
    else $error("step pulse while idle");
  a_zero_busy: assert property (
    speed_zero_flag |-> axis_busy_flag)
    else $error("speed zero without busy");
  a_zero_still: assert property (
    speed_zero_flag[*3] |-> !pulse_out)
    else $error("step pulse in speed zero state");
  a_dir_held: assert property (
    axis_busy_flag && $past(axis_busy_flag) |-> $stable(dir_out))
    else $error("direction changed while busy");
  a_limit_stop: assert property (hit_q < STOP_CLKS)
    else $error("axis kept running into a limit");
  c_start: cover property ($rose(axis_busy_flag));
  c_zero: cover property ($rose(speed_zero_flag));
  c_limit: cover property (hit_q == 16'h1);
endmodule // jamc_axis_monitor

bind jamc_axis jamc_axis_monitor mon_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .limit_upper(limit_upper), .limit_lower(limit_lower),
  .pulse_out(pulse_out), .dir_out(dir_out),
  .axis_busy_flag(axis_busy_flag), .speed_zero_flag(speed_zero_flag));

//--- tb/jamc_drive_model.sv
// step counter and limit switches standing in for the axis mechanics
`timescale 1ns/10ps
module jamc_drive_model #(
  parameter logic signed [31:0] LO_POS = -32'sh000f4240
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               pulse_out,
  input  wire logic               dir_out,
  input  wire logic signed [31:0] up_pos,
  output logic signed [31:0]      pos,
  output logic                    limit_upper,
  output logic                    limit_lower
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pos <= 32'sh0;
    else if (pulse_out)
      pos <= dir_out ? pos - 32'sh1 : pos + 32'sh1;
  end
  // both switches are always wired, so hard limiting is usable
  assign limit_upper = pos >= up_pos;
  assign limit_lower = pos <= LO_POS;
endmodule // jamc_drive_model

//--- tb/tb.sv
// self-checking bench for the jog axis block
`timescale 1ns/10ps
module tb;
  import jamc_pkg::*;
  typedef struct {logic [31:0] j, s, w;} jamc_row_t;
  typedef struct {logic [7:0] a; logic [31:0] v;} jamc_rv_t;
  logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
  logic               hwrite = 1'b0;
  logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata, rd, s1;
  logic [1:0]         htrans = 2'h0;
  logic [2:0]         hsize = 3'h2;
  logic               hreadyout, hresp, lim_up, lim_lo, pulse, dir;
  logic               busy, zero;
  logic signed [31:0] up_pos = 32'sh7fffffff, pos;
  int                 num_errors = 0, cmp_count = 0, cyc = 0;
  jamc_row_t rows[3] = '{'{32'hc350, 32'hc350, 32'h0},
    '{32'h1e8480, 32'hf4240, 32'h3fc}, '{32'h1f4, 32'h3e8, 32'h3fc}};
  jamc_rv_t regs[8] = '{'{A_LIMIT, RST_LIMIT}, '{A_ACCT, RST_TIME},
    '{A_DECT, RST_TIME}, '{A_SWUP, RST_ZERO}, '{A_STAT, RST_ZERO},
    '{A_ERR, RST_ZERO}, '{A_CMD, RST_ZERO}, '{8'h40, RST_ZERO}};

  jamc_axis dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .limit_upper(lim_up),
    .limit_lower(lim_lo), .pulse_out(pulse), .dir_out(dir),
    .axis_busy_flag(busy), .speed_zero_flag(zero));
  jamc_drive_model drv_u (.hclk(hclk), .hresetn(hresetn),
    .pulse_out(pulse), .dir_out(dir), .up_pos(up_pos), .pos(pos),
    .limit_upper(lim_up), .limit_lower(lim_lo));

  always #2 hclk = ~hclk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] e,
                      input string n);
    repeat (600) begin
      xfer(1'b0, a, 32'h0);
      if (rd === e) break;
    end
    chk(n, e, rd);
  endtask
  task automatic wb(input logic v);
    for (int i = 0; i < 8000 && busy !== v; i++) @(posedge hclk);
    chkb("busy", v, busy);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // the hang guard ends the run through the same report
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    wr(A_LIMIT, 32'hf4240);
    wr(A_BIAS, 32'h3e8);
    wr(A_ACCT, 32'h2);
    wr(A_DECT, 32'h2);
    foreach (rows[i]) begin
      wr(A_JOGSPD, rows[i].j);
      wr(A_CTRL, 32'h1);
      poll(A_SPEED, rows[i].s, "jog speed");
      rdchk(A_WARN, rows[i].w, "warning");
      rdchk(A_OPST, 32'h2, "op status");
      wr(A_CTRL, 32'h0);
      wb(1'b0);
      rdchk(A_SPEED, 32'h0, "end speed");
      wr(A_CMD, 32'h2);
    end
    wr(A_JOGSPD, 32'h30d40);
    wr(A_CTRL, 32'h4);
    wr(A_CTRL, 32'h5);
    rdchk(A_ERR, {16'h0, ERR_STOP_ON}, "stop error");
    chkb("busy", 1'b0, busy);
    wr(A_CTRL, 32'h4);
    wr(A_CMD, 32'h2);
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h1);
    wb(1'b1);
    wr(A_CTRL, 32'h5);
    wb(1'b0);
    wr(A_CTRL, 32'h1);
    repeat (800) @(posedge hclk);
    chkb("busy", 1'b0, busy);
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h1);
    poll(A_SPEED, 32'h30d40, "jog speed");
    wr(A_CTRL, 32'h0);
    wr(A_NEWSPD, 32'hf4240);
    wr(A_CMD, 32'h1);
    wr(A_CTRL, 32'h1);
    xfer(1'b0, A_SPEED, 32'h0);
    s1 = rd;
    repeat (300) @(posedge hclk);
    xfer(1'b0, A_SPEED, 32'h0);
    chkb("no speed up", 1'b1, rd <= s1);
    wb(1'b0);
    repeat (800) @(posedge hclk);
    chkb("busy", 1'b0, busy);
    wr(A_CTRL, 32'h0);
    wr(A_BIAS, 32'h0);
    wr(A_JOGSPD, 32'h0);
    wr(A_CTRL, 32'h1);
    wb(1'b1);
    rdchk(A_STAT, 32'h3, "status");
    rdchk(A_OPST, 32'h2, "op status");
    // a retarget ramps with a step taken from the target, so a small
    // new speed keeps the later ramp down to the bias speed short
    wr(A_NEWSPD, 32'h7d0);
    wr(A_CMD, 32'h1);
    poll(A_SPEED, 32'h7d0, "new speed");
    chkb("speed zero", 1'b0, zero);
    wr(A_BIAS, 32'h3e8);
    wr(A_NEWSPD, 32'h0);
    wr(A_CMD, 32'h1);
    poll(A_SPEED, 32'h3e8, "bias speed");
    rdchk(A_WARN, 32'h3fc, "warning");
    wr(A_CTRL, 32'h0);
    wb(1'b0);
    wr(A_CMD, 32'h2);
    wr(A_JOGSPD, 32'hf4240);
    up_pos <= pos + 32'sh8;
    wr(A_CTRL, 32'h1);
    wb(1'b1);
    wb(1'b0);
    rdchk(A_ERR, {16'h0, ERR_HW_UP}, "limit error");
    wr(A_CMD, 32'h2);
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h3);
    wb(1'b1);
    rdchk(A_STAT, 32'h5, "status");
    chkb("direction", 1'b1, dir);
    wr(A_CTRL, 32'h1);
    chkb("direction", 1'b1, dir);
    wr(A_CTRL, 32'h2);
    wb(1'b0);
    up_pos <= 32'sh7fffffff;
    xfer(1'b0, A_FEED, 32'h0);
    wr(A_SWUP, rd + 32'h8);
    wr(A_SWLO, rd - 32'h100000);
    wr(A_CTRL, 32'h1);
    wb(1'b1);
    wb(1'b0);
    rdchk(A_ERR, {16'h0, ERR_SW_UP}, "soft error");
    wr(A_CMD, 32'h2);
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h1);
    rdchk(A_ERR, {16'h0, ERR_SW_UP}, "refused start");
    chkb("busy", 1'b0, busy);
    xfer(1'b0, A_FEED, 32'h0);
    wr(A_SWLO, rd - 32'h8);
    wr(A_CMD, 32'h2);
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h3);
    wb(1'b1);
    wb(1'b0);
    rdchk(A_ERR, {16'h0, ERR_SW_LO}, "soft low error");
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    wr(8'h40, 32'hffffffff);
    wr(A_STAT, 32'hffffffff);
    foreach (regs[i]) rdchk(regs[i].a, regs[i].v, "register");
    chkb("busy", 1'b0, busy);
    tally_and_finish;
  end
endmodule // tb
